// File: design/dual_ddc.sv
`timescale 1ns/10ps
`include "ddc_defines.svh"

// Behaviour
// RULE1: two independent channels share one sample stream
// RULE2: real samples times complex tone give I, Q
// RULE3: 10-bit oscillator, 1024 tunings, step fs/1024
// RULE4: phase accumulator addresses sine lookup table
// RULE5: software writes 10-bit increment per channel
// RULE6: first channel increment is high[1:0] and low[7:0]
// RULE7: second channel increment built the same way
// RULE8: first stage decimates by 8, one output per clock
// RULE9: first stage takes eight 13-bit mixer samples
// RULE10: whole block runs on one core clock
// RULE11: first stage gain 0-18 dB before rounding
// RULE12: first stage symmetric 142 taps, 17-bit coefficients; the code holds them as 18-bit coef_t
// RULE13: low bandwidth mode adds decimate by 2
// RULE14: second stage shares one engine for I, Q
// RULE15: second stage gain 0-18 dB before 16-bit rounding
// RULE16: second stage symmetric 31 taps, fixed coefficients
// RULE17: each channel outputs its own 16-bit I, Q
// RULE18: accumulator adds increment per sample, modulo 1024
// RULE19: gain is left shift; rounding saturates
module dual_ddc (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Converter samples, eight per clock, oldest in the low bits
  input wire logic [95:0] SAMPLE_DATA,
  input wire logic SAMPLE_VALID,
  // Avalon-MM slave
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // First downconverter output
  output ddc_pkg::iq_t A_I_DATA,
  output ddc_pkg::iq_t A_Q_DATA,
  output logic A_VALID,
  // Second downconverter output
  output ddc_pkg::iq_t B_I_DATA,
  output ddc_pkg::iq_t B_Q_DATA,
  output logic B_VALID
);
  import ddc_pkg::*;

  // Unique half of each symmetric response, outer tap first
  localparam coef_t H1 [0:70] = '{
    -38, -57, -92, -132, -172, -204, -219, -207, -162, -79, 43, 196,
    369, 540, 685, 780, 800, 727, 554, 289, -48, -420, -778, -1069,
    -1238, -1242, -1055, -677, -135, 513, 1186, 1785, 2210, 2372, 2209,
    1698, 869, -200, -1382, -2516, -3425, -3945, -3944, -3353, -2179,
    -519, 1446, 3467, 5250, 6496, 6945, 6412, 4831, 2276, -1031, -4725,
    -8330, -11304, -13098, -13222, -11306, -7160, -808, 7498, 17281,
    27882, 38515, 48340, 56550, 62451, 65536};
  localparam coef_t H2 [0:15] = '{
    126, 312, -16, -859, -628, 1217, 1428, -1944, -3227, 2511, 6302,
    -3099, -13075, 3441, 43442, 65536};
  // Quarter wave of sine, 64 points per turn
  localparam adc_t QSIN [0:16] = '{
    0, 201, 399, 594, 783, 965, 1137, 1299, 1447, 1582, 1702, 1805,
    1891, 1959, 2008, 2037, 2047};

  function automatic adc_t sin_lut(input logic [5:0] p);
    logic [4:0] idx;
    adc_t mag;
    idx = p[4] ? (5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
    mag = QSIN[idx];
    sin_lut = p[5] ? -mag : mag;
  endfunction

  // Gain shift, round half up, clip; bit 16 flags a clip
  function automatic logic [16:0] scale16(input acc_t a,
                                          input logic [1:0] g,
                                          input int sh);
    acc_t v;
    v = (a <<< g) + (acc_t'(1) <<< (sh - 1)); // see RULE11 see RULE15
    v = v >>> sh;
    if (v > acc_t'(32767)) begin
      scale16 = 17'h17fff; // see RULE19
    end else if (v < acc_t'(-32768)) begin
      scale16 = 17'h18000; // see RULE19
    end else begin
      scale16 = {1'b0, v[15:0]};
    end
  endfunction

  // Register file
  logic wait_q;
  logic [31:0] rdata_q;
  logic [7:0] a_low_q, a_high_q, b_low_q, b_high_q;
  logic [7:0] mode_q, gain_q;
  logic [1:0] sat_q;
  logic [9:0] idx;
  logic wr_en;
  logic [7:0] rd_d;
  logic [1:0] sat_ev;
  phase_t inc [0:1];
  logic [1:0] low_bw;
  logic [1:0] g1 [0:1];
  logic [1:0] g2 [0:1];

  assign idx = AVS_ADDRESS[11:2];
  assign wr_en = AVS_WRITE && !wait_q && AVS_BYTEENABLE[0];

  // One wait cycle for every access
  always_ff @(posedge MCLK) begin
    if (RST) begin
      wait_q <= 1'b1;
    end else if ((AVS_READ || AVS_WRITE) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_comb begin
    case (idx)
      `IDX_A_TUNE_LOW: rd_d = a_low_q;
      `IDX_A_TUNE_HIGH: rd_d = a_high_q;
      `IDX_B_TUNE_LOW: rd_d = b_low_q;
      `IDX_B_TUNE_HIGH: rd_d = b_high_q;
      `IDX_MODE_CTRL: rd_d = mode_q;
      `IDX_GAIN_CTRL: rd_d = gain_q;
      `IDX_SAT_STATUS: rd_d = {6'h00, sat_q};
      default: rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      rdata_q <= 32'h0;
    end else if (AVS_READ && wait_q) begin
      rdata_q <= {24'h0, rd_d};
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      a_low_q <= `TUNE_RST;
      a_high_q <= `TUNE_RST;
      b_low_q <= `TUNE_RST;
      b_high_q <= `TUNE_RST;
      mode_q <= `MODE_RST;
      gain_q <= `GAIN_RST;
    end else if (wr_en) begin
      case (idx)
        `IDX_A_TUNE_LOW: a_low_q <= AVS_WRITEDATA[7:0]; // see RULE5
        `IDX_A_TUNE_HIGH: a_high_q <= AVS_WRITEDATA[7:0];
        `IDX_B_TUNE_LOW: b_low_q <= AVS_WRITEDATA[7:0];
        `IDX_B_TUNE_HIGH: b_high_q <= AVS_WRITEDATA[7:0];
        `IDX_MODE_CTRL: mode_q <= AVS_WRITEDATA[7:0];
        `IDX_GAIN_CTRL: gain_q <= AVS_WRITEDATA[7:0];
        default: ;
      endcase
    end
  end

  // Clip flags: write one clears, a new clip wins over the clear
  always_ff @(posedge MCLK) begin
    if (RST) begin
      sat_q <= `SAT_RST;
    end else if (wr_en && idx == `IDX_SAT_STATUS) begin
      sat_q <= (sat_q & ~AVS_WRITEDATA[1:0]) | sat_ev;
    end else begin
      sat_q <= sat_q | sat_ev;
    end
  end

  assign inc[0] = {a_high_q[`TUNE_HIGH_MSB:0], a_low_q}; // see RULE6
  assign inc[1] = {b_high_q[`TUNE_HIGH_MSB:0], b_low_q}; // see RULE7
  assign low_bw = {mode_q[`MODE_LOWBW_B], mode_q[`MODE_LOWBW_A]};
  assign g1[0] = gain_q[`GAIN_S1_LSB +: 2];
  assign g2[0] = gain_q[`GAIN_S2_LSB +: 2];
  assign g1[1] = gain_q[`GAIN_FIELD_W + `GAIN_S1_LSB +: 2];
  assign g2[1] = gain_q[`GAIN_FIELD_W + `GAIN_S2_LSB +: 2];

  // Samples reach the history one edge after arrival
  logic hv_q;
  always_ff @(posedge MCLK) begin
    if (RST) begin
      hv_q <= 1'b0;
    end else begin
      hv_q <= SAMPLE_VALID;
    end
  end

  for (genvar c = 0; c < 2; c++) begin : g_ch // see RULE1 see RULE10
    phase_t acc_q;
    mix_t mix [0:1][0:7];
    iq_t s1_q [0:1];
    logic s1_v_q;
    logic s1_clip;

    // Eight phases per clock, one increment apart
    always_ff @(posedge MCLK) begin
      if (RST) begin
        acc_q <= 10'h000;
      end else if (SAMPLE_VALID) begin
        acc_q <= acc_q + {inc[c][6:0], 3'b000}; // see RULE18 see RULE3
      end
    end

    always_comb begin
      phase_t ph;
      adc_t x;
      logic signed [23:0] pi;
      logic signed [23:0] pq;
      ph = acc_q;
      x = '0;
      pi = '0;
      pq = '0;
      for (int k = 0; k < 8; k++) begin
        x = adc_t'(SAMPLE_DATA[12*k +: 12]);
        // Tone is cos - j sin, addressed by the top six phase bits
        pi = 24'(x) * 24'(sin_lut(ph[9:4] + 6'h10)); // see RULE4
        pq = -(24'(x) * 24'(sin_lut(ph[9:4]))); // see RULE2
        mix[0][k] = pi[23:11];
        mix[1][k] = pq[23:11];
        ph = ph + inc[c]; // see RULE18
      end
    end

    for (genvar b = 0; b < 2; b++) begin : g_br
      mix_t hist_q [0:`S1_TAPS-1];
      acc_t s1_acc;
      logic [16:0] sc;

      // Newest sample at index 0
      always_ff @(posedge MCLK) begin
        if (RST) begin
          for (int j = 0; j < `S1_TAPS; j++) begin
            hist_q[j] <= '0;
          end
        end else if (SAMPLE_VALID) begin
          for (int j = 0; j < 8; j++) begin
            hist_q[j] <= mix[b][7-j]; // see RULE9
          end
          for (int j = 8; j < `S1_TAPS; j++) begin
            hist_q[j] <= hist_q[j-8];
          end
        end
      end

      always_comb begin
        logic signed [13:0] p;
        p = '0;
        s1_acc = '0;
        for (int j = 0; j < `S1_HALF; j++) begin
          p = 14'(hist_q[j]) + 14'(hist_q[`S1_TAPS-1-j]); // see RULE12
          s1_acc = s1_acc + acc_t'(H1[j]) * acc_t'(p);
        end
      end

      assign sc = scale16(s1_acc, g1[c], `S1_SHIFT);

      // One output per block of eight inputs
      always_ff @(posedge MCLK) begin
        if (RST) begin
          s1_q[b] <= '0;
        end else if (hv_q) begin
          s1_q[b] <= iq_t'(sc[15:0]); // see RULE8
        end
      end
    end

    assign s1_clip = hv_q && (g_br[0].sc[16] || g_br[1].sc[16]);

    always_ff @(posedge MCLK) begin
      if (RST) begin
        s1_v_q <= 1'b0;
      end else begin
        s1_v_q <= hv_q;
      end
    end

    // Second stage: I on the pair's second input, Q the next cycle
    iq_t s2i_q [0:`S2_TAPS-1];
    iq_t s2q_q [0:`S2_TAPS-1];
    logic ph2_q;
    s2_slot_e slot_q;
    iq_t ihold_q;
    iq_t w [0:`S2_TAPS-1];
    acc_t acc2;
    logic [16:0] sc2;
    logic fire_i;

    assign fire_i = low_bw[c] && s1_v_q && ph2_q && slot_q == SLOT_IDLE;

    always_ff @(posedge MCLK) begin
      if (RST) begin
        for (int j = 0; j < `S2_TAPS; j++) begin
          s2i_q[j] <= '0;
          s2q_q[j] <= '0;
        end
      end else if (s1_v_q) begin
        s2i_q[0] <= s1_q[0];
        s2q_q[0] <= s1_q[1];
        for (int j = 1; j < `S2_TAPS; j++) begin
          s2i_q[j] <= s2i_q[j-1];
          s2q_q[j] <= s2q_q[j-1];
        end
      end
    end

    always_ff @(posedge MCLK) begin
      if (RST) begin
        ph2_q <= 1'b0;
      end else if (!low_bw[c]) begin
        ph2_q <= 1'b0;
      end else if (s1_v_q) begin
        ph2_q <= !ph2_q; // see RULE13
      end
    end

    always_ff @(posedge MCLK) begin
      if (RST) begin
        slot_q <= SLOT_IDLE;
      end else begin
        case (slot_q)
          SLOT_IDLE: slot_q <= fire_i ? SLOT_Q : SLOT_IDLE;
          SLOT_Q: slot_q <= SLOT_IDLE;
          default: slot_q <= SLOT_IDLE;
        endcase
      end
    end

    // Shared engine input: I window includes the arriving sample
    always_comb begin
      for (int j = 0; j < `S2_TAPS; j++) begin
        if (slot_q == SLOT_Q) begin
          w[j] = s2q_q[j]; // see RULE14
        end else if (j == 0) begin
          w[j] = s1_q[0];
        end else begin
          w[j] = s2i_q[j-1];
        end
      end
    end

    always_comb begin
      logic signed [16:0] p;
      p = '0;
      acc2 = acc_t'(H2[`S2_HALF]) * acc_t'(w[`S2_HALF]); // see RULE16
      for (int j = 0; j < `S2_HALF; j++) begin
        p = 17'(w[j]) + 17'(w[`S2_TAPS-1-j]);
        acc2 = acc2 + acc_t'(H2[j]) * acc_t'(p);
      end
    end

    assign sc2 = scale16(acc2, g2[c], `S2_SHIFT);

    always_ff @(posedge MCLK) begin
      if (RST) begin
        ihold_q <= '0;
      end else if (fire_i) begin
        ihold_q <= iq_t'(sc2[15:0]);
      end
    end

    assign sat_ev[c] = s1_clip || ((fire_i || slot_q == SLOT_Q) && sc2[16]);

    // Output port of this channel
    iq_t oi_q, oq_q;
    logic ov_q;
    always_ff @(posedge MCLK) begin
      if (RST) begin
        oi_q <= '0;
        oq_q <= '0;
        ov_q <= 1'b0;
      end else if (!low_bw[c]) begin
        ov_q <= s1_v_q; // see RULE17
        if (s1_v_q) begin
          oi_q <= s1_q[0];
          oq_q <= s1_q[1];
        end
      end else if (slot_q == SLOT_Q) begin
        ov_q <= 1'b1; // see RULE13
        oi_q <= ihold_q;
        oq_q <= iq_t'(sc2[15:0]);
      end else begin
        ov_q <= 1'b0;
      end
    end
  end

  assign AVS_WAITREQUEST = wait_q;
  assign AVS_READDATA = rdata_q;
  assign A_I_DATA = g_ch[0].oi_q;
  assign A_Q_DATA = g_ch[0].oq_q;
  assign A_VALID = g_ch[0].ov_q;
  assign B_I_DATA = g_ch[1].oi_q;
  assign B_Q_DATA = g_ch[1].oq_q;
  assign B_VALID = g_ch[1].ov_q;

endmodule // dual_ddc

// File: dv/adc_source.sv
`timescale 1ns/10ps
module adc_source (
  // Clock
  input wire logic mclk,
  // Sample stream
  output logic [95:0] sample_data,
  output logic sample_valid
);
  initial begin
    sample_data = 96'h0;
    sample_valid = 1'b0;
  end
  // First word holds x in slot k0, every word in all slots if k0 > 7
  task automatic stream(input logic [11:0] x, input int k0, n, gap);
    logic [95:0] w;
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < 8; k++) begin
        w[12*k +: 12] = (k0 > 7 || (i == 0 && k == k0)) ? x : 12'h000;
      end
      @(posedge mclk);
      sample_data <= w;
      sample_valid <= 1'b1;
      repeat (gap) begin
        @(posedge mclk);
        sample_valid <= 1'b0;
        sample_data <= ~w;
      end
    end
    @(posedge mclk);
    sample_valid <= 1'b0;
    sample_data <= ~w;
  endtask
endmodule // adc_source

// File: dv/ddc_checker_sva.sv
`timescale 1ns/10ps
module ddc_checker (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Sample stream
  input wire logic SAMPLE_VALID,
  // Register bus
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // Channel outputs
  input wire ddc_pkg::iq_t A_I_DATA,
  input wire ddc_pkg::iq_t A_Q_DATA,
  input wire logic A_VALID,
  input wire ddc_pkg::iq_t B_I_DATA,
  input wire ddc_pkg::iq_t B_Q_DATA,
  input wire logic B_VALID
);
  import ddc_pkg::*;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  wait_one_cycle_a: assert property (
    $fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  bus_answer_a: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("no answer one cycle after request");
  bus_idle_a: assert property (
    !(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer without request");
  upper_zero_a: assert property (
    !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h000000)
    else $error("read data upper bits set");
  unmapped_zero_a: assert property (
    AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS[11:2] < 10'h131
    |=> AVS_READDATA == 32'h00000000)
    else $error("unmapped read not zero");
  output_cause_a: assert property (
    (A_VALID || B_VALID) |-> $past(SAMPLE_VALID, 3) ||
    $past(SAMPLE_VALID, 4) || $past(SAMPLE_VALID, 5))
    else $error("output without input");
  hold_first_a: assert property (
    !A_VALID |-> $stable(A_I_DATA) && $stable(A_Q_DATA))
    else $error("first channel data moved");
  hold_second_a: assert property (
    !B_VALID |-> $stable(B_I_DATA) && $stable(B_Q_DATA))
    else $error("second channel data moved");
  reset_state_a: assert property (
    disable iff (1'b0) RST |=> AVS_WAITREQUEST && !A_VALID &&
    !B_VALID && A_I_DATA == 16'sh0000)
    else $error("outputs active in reset");
  cover property (A_VALID && B_VALID);
  cover property (AVS_WRITE && !AVS_WAITREQUEST);
  cover property (A_VALID && A_I_DATA == 16'sh7fff);
endmodule // ddc_checker

// File: dv/tb_dual_ddc.sv
`timescale 1ns/10ps
`include "ddc_defines.svh"
module tb_dual_ddc;
  import ddc_pkg::*;
  logic MCLK, RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic A_VALID, B_VALID, SAMPLE_VALID;
  logic [95:0] SAMPLE_DATA;
  logic [11:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA;
  logic [3:0] AVS_BYTEENABLE;
  iq_t A_I_DATA, A_Q_DATA, B_I_DATA, B_Q_DATA;
  iq_t cap[4];
  int errors, comparisons, na, nb;
  logic [7:0] q;
  logic [9:0] idx[4] = '{`IDX_A_TUNE_LOW, `IDX_A_TUNE_HIGH,
                         `IDX_B_TUNE_LOW, `IDX_B_TUNE_HIGH};
  logic [7:0] val[4] = '{8'h3c, 8'hfe, 8'hc3, 8'h02};
  logic [11:0] dc[2] = '{12'h7ff, 12'h800};
  iq_t sat[2] = '{16'sh7fff, -16'sh8000};
  dual_ddc i_dual_ddc (.MCLK(MCLK), .RST(RST), .SAMPLE_DATA(SAMPLE_DATA),
    .SAMPLE_VALID(SAMPLE_VALID), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .A_I_DATA(A_I_DATA), .A_Q_DATA(A_Q_DATA), .A_VALID(A_VALID),
    .B_I_DATA(B_I_DATA), .B_Q_DATA(B_Q_DATA), .B_VALID(B_VALID));
  adc_source i_adc_source (.mclk(MCLK), .sample_data(SAMPLE_DATA),
    .sample_valid(SAMPLE_VALID));
  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end
  task automatic fail(input string m);
    errors++;
    $display("FAIL %0t %s", $time, m);
  endtask
  task automatic cmp8(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) fail($sformatf("reg %h exp %h", got, exp));
  endtask
  task automatic cmp16(input iq_t got, exp);
    comparisons++;
    if (got !== exp) fail($sformatf("sample %0d exp %0d", got, exp));
  endtask
  task automatic cmpn(input int got, exp);
    comparisons++;
    if (got != exp) fail($sformatf("count %0d exp %0d", got, exp));
  endtask
  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [7:0] d, input logic [3:0] be);
    int t;
    @(posedge MCLK);
    AVS_ADDRESS <= {a, 2'b00};
    AVS_WRITEDATA <= {24'h000000, d};
    AVS_BYTEENABLE <= be;
    AVS_WRITE <= wr;
    AVS_READ <= ~wr;
    t = 0;
    do begin
      @(posedge MCLK);
      t++;
    end while (AVS_WAITREQUEST !== 1'b0 && t < 50);
    q = AVS_READDATA[7:0];
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    if (t >= 50) fail("bus timeout");
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'h0);
    cmp8(q, exp);
  endtask
  task automatic reset();
    RST <= 1'b1;
    repeat (8) @(posedge MCLK);
    RST <= 1'b0;
  endtask
  // Counts output pulses and keeps all four samples of the n-th first one
  task automatic watch(input int n, cyc);
    na = 0;
    nb = 0;
    repeat (cyc) begin
      @(posedge MCLK);
      if (B_VALID === 1'b1) nb++;
      if (A_VALID === 1'b1) begin
        na++;
        if (na == n) cap = '{A_I_DATA, A_Q_DATA, B_I_DATA, B_Q_DATA};
      end
    end
  endtask
  task automatic results();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    fail("watchdog");
    results();
  end
  initial begin
    RST = 1'b1;
    AVS_ADDRESS = 12'h000;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h0;
    AVS_BYTEENABLE = 4'h0;
    errors = 0;
    comparisons = 0;
    reset();
    foreach (idx[i]) rd(idx[i], 8'h00);
    foreach (idx[i]) wr(idx[i], val[i]);
    foreach (idx[i]) rd(idx[i], val[i]);
    bus(1'b1, idx[0], 8'h55, 4'h0);
    rd(idx[0], val[0]);
    wr(10'h000, 8'h77);
    rd(10'h000, 8'h00);
    // Impulse in slot 1 reaches the centre tap on the ninth output
    reset();
    wr(idx[1], 8'hfe);
    wr(idx[3], 8'h01);
    fork
      i_adc_source.stream(12'h400, 1, 20, 0);
      watch(9, 60);
    join
    cmp16(cap[0], -16'sh0400);
    cmp16(cap[1], 16'sh0000);
    cmp16(cap[2], 16'sh0000);
    cmp16(cap[3], -16'sh0400);
    // Full-scale DC with 18 dB of first-stage gain must clip
    reset();
    wr(`IDX_GAIN_CTRL, 8'h03);
    foreach (dc[i]) begin
      fork
        i_adc_source.stream(dc[i], 8, 30, 0);
        watch(25, 50);
      join
      cmp16(cap[0], sat[i]);
      cmp16(cap[1], 16'sh0000);
    end
    rd(`IDX_SAT_STATUS, 8'h01);
    wr(`IDX_SAT_STATUS, 8'h01);
    rd(`IDX_SAT_STATUS, 8'h00);
    // Low bandwidth on the first channel only, source stalling
    reset();
    wr(`IDX_MODE_CTRL, 8'h01);
    fork
      i_adc_source.stream(12'h000, 8, 40, 1);
      watch(0, 130);
    join
    cmpn(na, 20);
    cmpn(nb, 40);
    // Low bandwidth on the second channel, full-scale DC once filled
    reset();
    wr(`IDX_MODE_CTRL, 8'h02);
    fork
      i_adc_source.stream(12'h7ff, 8, 70, 0);
      watch(70, 80);
    join
    cmpn(na, 70);
    cmpn(nb, 35);
    cmp16(cap[0], 16'sh43ef);
    cmp16(cap[1], 16'sh0000);
    cmp16(cap[2], 16'sh4736);
    cmp16(cap[3], 16'sh0000);
    results();
  end
endmodule // tb_dual_ddc
bind dual_ddc ddc_checker i_ddc_checker (.MCLK(MCLK), .RST(RST),
  .SAMPLE_VALID(SAMPLE_VALID), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .A_I_DATA(A_I_DATA), .A_Q_DATA(A_Q_DATA), .A_VALID(A_VALID),
  .B_I_DATA(B_I_DATA), .B_Q_DATA(B_Q_DATA), .B_VALID(B_VALID));

// File: include/ddc_defines.svh
`ifndef DDC_DEFINES_SVH
`define DDC_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_A_TUNE_LOW 10'h131
`define IDX_A_TUNE_HIGH 10'h132
`define IDX_B_TUNE_LOW 10'h139
`define IDX_B_TUNE_HIGH 10'h13a
`define IDX_MODE_CTRL 10'h140
`define IDX_GAIN_CTRL 10'h141
`define IDX_SAT_STATUS 10'h142

// Field positions
`define TUNE_HIGH_MSB 1
`define MODE_LOWBW_A 0
`define MODE_LOWBW_B 1
`define GAIN_FIELD_W 4
`define GAIN_S1_LSB 0
`define GAIN_S2_LSB 2

// Reset values
`define TUNE_RST 8'h00
`define MODE_RST 8'h00
`define GAIN_RST 8'h00
`define SAT_RST 2'h0

// Filter geometry and output scaling
`define S1_TAPS 142
`define S1_HALF 71
`define S2_TAPS 31
`define S2_HALF 15
`define S1_SHIFT 16
`define S2_SHIFT 17

`endif

// File: include/ddc_pkg.sv
package ddc_pkg;
  typedef logic signed [11:0] adc_t;
  typedef logic signed [12:0] mix_t;
  typedef logic signed [15:0] iq_t;
  typedef logic signed [17:0] coef_t;
  typedef logic signed [43:0] acc_t;
  typedef logic [9:0] phase_t;
  typedef enum logic {SLOT_IDLE, SLOT_Q} s2_slot_e;
endpackage
